// file: inc/ttymf_map.svh
// Constants of the teletypewriter message formatter.
// Assumes a 16-bit word store of 16 groups of eight words.
`ifndef TTYMF_MAP_SVH
`define TTYMF_MAP_SVH
// ----------------------------------------------------------------
// Register port
// ----------------------------------------------------------------
`define TTYMF_ADDR_TOD 8'h80
`define TTYMF_ADDR_STATUS 8'h81
`define TTYMF_ADDR_ACK 8'h82
`define TTYMF_STORE_TOP 1'h1
// ----------------------------------------------------------------
// Progress marks kept in group word 0
// ----------------------------------------------------------------
`define TTYMF_MARK_NONE 4'h0
`define TTYMF_MARK_STD 4'h1
`define TTYMF_MARK_PIN 4'h2
`define TTYMF_MARK_CHK 4'h3
`define TTYMF_MARK_INT 4'h4
`define TTYMF_MARK_TOD 4'h5
`define TTYMF_MARK_DONE 4'h6
// ----------------------------------------------------------------
// Character codes
// ----------------------------------------------------------------
`define TTYMF_C_SPACE 5'h18
`define TTYMF_C_LR 5'h11
`define TTYMF_C_PERIOD 5'h12
`define TTYMF_C_LRBELL 5'h1c
`define TTYMF_C_ONE 5'h01
`define TTYMF_C_L 5'h1b
`define TTYMF_C_E 5'h14
`define TTYMF_C_G 5'h17
`define TTYMF_C_A 5'h13
`define TTYMF_C_DASH 5'h00
`define TTYMF_C_LAST 5'h1f
// ----------------------------------------------------------------
// Layout
// ----------------------------------------------------------------
`define TTYMF_W_FIRST 3'h1
`define TTYMF_W_LAST 3'h7
`define TTYMF_W_LINE1 3'h3
`define TTYMF_W_INT0 3'h5
`define TTYMF_W_INT1 3'h6
`define TTYMF_W_INT2 3'h7
`define TTYMF_W1_LASTCHR 2'h2
`define TTYMF_LASTCHR 2'h3
`define TTYMF_INT_LASTCHR 2'h2
`endif

// file: inc/ttymf_pkg.sv
// Types of the teletypewriter message formatter.
// Assumes ttymf_map.svh supplies the encodings.
`include "ttymf_map.svh"
package ttymf_pkg;
  typedef enum logic [3:0] {
    TTYMF_ST_WAIT = 4'h1,
    TTYMF_ST_LOAD = 4'h2,
    TTYMF_ST_HIGH = 4'h4,
    TTYMF_ST_LOW = 4'h8
  } ttymf_state_type;
  // Position of the next character within a group
  typedef struct packed {
    logic [2:0] word_idx;
    logic [1:0] chr_idx;
    logic sep;
  } ttymf_ctl_type;
  // Print-out register image: busy, top bit, low four bits
  typedef struct packed {
    logic busy;
    logic top;
    logic [3:0] low;
  } ttymf_por_type;
endpackage : ttymf_pkg

// file: verilog/ttymf_formatter.sv
// Teletypewriter message formatter: message store, print-out and print-in.
// Assumes scan_tick pulses once per processor scan and that the printer
// side clears por_busy when a character has gone out.
//
// Notes on behaviour
// (R1) Top code bit is 0 for legal, 1 for functional characters.
// (R2) Legal codes: dash 0, digits 1-9, zero 10, then M S C T R.
// (R3) Space 11000, line return 10001, period 10010, bell return 11100.
// (R4) First line holds words of 3, 4, 4 characters; four one-word lines.
// (R5) Space between words on a line, line return before a new line.
// (R6) Sixteen groups, each one print-in or print-out message.
// (R7) Eight words per group; word 0 carries the progress mark.
// (R8) Word 1 holds first word in bits 1-12; 13-16 reserved.
// (R9) Only low four bits stored; top bit given by high part transfer.
// (R10) Rotate word until character sits in bits 13-16, then send it.
// (R11) Space and line return come from constants via the working register.
// (R12) Control word counts characters, places separators, picks word, shift.
// (R13) Print-in steers legal characters into place; functional discarded.
// (R14) Intermediate messages in last three words, five bits per character.
// (R15) Send leading character, shift word five, write back; one per scan.
// (R16) Invalid print-in message answers with ILLEGAL spelled with digit one.
// (R17) Time of day printed at the end of every message sequence.
// (R18) Check mode prints every teletypewriter character in turn.
// (R19) Completed print-in group handed to the maintenance request handler.
// (R20) High part transfer sets busy bit and the character top bit.
// (R21) Next character written only after per-scan check shows idle.
// (R22) Period ends a print-in message; operator ends each with a period.
// (R23) One group served at a time; groups with no pending mark skipped.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "ttymf_map.svh"
module ttymf_formatter import ttymf_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_r,
  input wire logic scan_tick,
  input wire logic por_busy,
  input wire logic pin_strobe,
  input wire logic [4:0] pin_char,
  output ttymf_por_type por_data_r,
  output logic por_high_load_r,
  output logic por_low_load_r,
  output logic por_start_r,
  output logic handoff_pend_r,
  output logic [3:0] handoff_group_r
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Character k is brought to bits 13-16 by rotating k+1 places of four (see (R10))
  function automatic logic [15:0] ttymf_rotl4(input logic [15:0] w,
                                              input logic [1:0] k);
    case (k)
      2'h0: ttymf_rotl4 = {w[11:0], w[15:12]};
      2'h1: ttymf_rotl4 = {w[7:0], w[15:8]};
      2'h2: ttymf_rotl4 = {w[3:0], w[15:4]};
      default: ttymf_rotl4 = w;
    endcase
  endfunction : ttymf_rotl4
  // Five-bit packing: first character top bit in bit 1, low bits in 13-16 (see (R14))
  function automatic logic [15:0] ttymf_pack3(input logic [4:0] c0,
                                              input logic [4:0] c1,
                                              input logic [4:0] c2);
    ttymf_pack3 = {c0[4], c1[3:0], c1[4], c2[3:0], c2[4], 1'b0, c0[3:0]};
  endfunction : ttymf_pack3
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] store_mem [0:127];
  ttymf_state_type state_r;
  ttymf_ctl_type control_word_r;
  logic [3:0] grp_r;
  logic [15:0] working_register_r;
  logic top_r;
  logic [4:0] chk_r;
  logic pin_bad_r;
  logic [15:0] tod_r;
  logic [15:0] cur_word;
  logic [3:0] mark;
  logic pin_take;
  logic pin_func;
  logic pin_full;
  logic seq_end;
  logic int_end;
  logic [15:0] int_next;
  logic [15:0] nib_word;
  logic [6:0] grp_base;
  assign grp_base = {grp_r, 3'h0};
  assign mark = store_mem[grp_base][3:0];
  assign cur_word = store_mem[grp_base | {4'h0, control_word_r.word_idx}];
  // Shift left five: the sent character drops out, so an emptied tail
  // reads zero; trailing dashes are therefore never printed
  assign int_next = {working_register_r[10:4], 5'h00,
                     working_register_r[14:11]}; // see (R15)
  assign pin_func = pin_char[4];
  // Word index wraps to zero once word 7 is filled
  assign pin_full = control_word_r.word_idx < `TTYMF_W_FIRST;
  assign pin_take = pin_strobe && state_r == TTYMF_ST_WAIT &&
                    mark == `TTYMF_MARK_PIN;
  // Legal character overwrites its nibble, bits 1-4 first (see (R13))
  always_comb begin
    nib_word = cur_word;
    case (control_word_r.chr_idx)
      2'h0: nib_word[15:12] = pin_char[3:0]; // see (R2)
      2'h1: nib_word[11:8] = pin_char[3:0];
      2'h2: nib_word[7:4] = pin_char[3:0];
      default: nib_word[3:0] = pin_char[3:0];
    endcase
  end
  // Last character of the current sequence is going out in this cycle
  always_comb begin
    int_end = control_word_r.word_idx == `TTYMF_W_INT2 &&
              (int_next == 16'h0000 ||
               control_word_r.chr_idx == `TTYMF_INT_LASTCHR);
    case (mark)
      `TTYMF_MARK_STD: seq_end = !control_word_r.sep &&
          control_word_r.word_idx == `TTYMF_W_LAST &&
          control_word_r.chr_idx == `TTYMF_LASTCHR;
      `TTYMF_MARK_CHK: seq_end = chk_r == `TTYMF_C_LAST;
      `TTYMF_MARK_INT: seq_end = int_end;
      `TTYMF_MARK_TOD: seq_end = !control_word_r.sep &&
          control_word_r.chr_idx == `TTYMF_LASTCHR;
      default: seq_end = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= TTYMF_ST_WAIT;
    end else begin
      case (state_r)
        TTYMF_ST_WAIT: begin
          if (scan_tick && !por_busy && (mark == `TTYMF_MARK_STD ||
              mark == `TTYMF_MARK_CHK || mark == `TTYMF_MARK_INT ||
              mark == `TTYMF_MARK_TOD)) begin // see (R21)
            state_r <= TTYMF_ST_LOAD;
          end
        end
        TTYMF_ST_LOAD: state_r <= TTYMF_ST_HIGH;
        TTYMF_ST_HIGH: state_r <= TTYMF_ST_LOW;
        TTYMF_ST_LOW: state_r <= TTYMF_ST_WAIT;
        default: state_r <= TTYMF_ST_WAIT;
      endcase
    end
  end
  // Idle groups are skipped one per cycle; print-in holds the group
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      grp_r <= 4'h0;
    end else if (state_r == TTYMF_ST_WAIT && (mark == `TTYMF_MARK_NONE ||
                 mark == `TTYMF_MARK_DONE || mark > `TTYMF_MARK_DONE)) begin
      grp_r <= grp_r + 4'h1; // see (R23)
    end
  end
  // Working register takes the rotated word, the raw word, the check code or a constant
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      working_register_r <= 16'h0000;
      top_r <= 1'b0;
    end else if (state_r == TTYMF_ST_LOAD) begin
      if (mark == `TTYMF_MARK_CHK) begin
        working_register_r <= {12'h000, chk_r[3:0]}; // see (R18)
        top_r <= chk_r[4];
      end else if (mark == `TTYMF_MARK_INT) begin
        working_register_r <= cur_word; // see (R15)
        top_r <= cur_word[15];
      end else if (control_word_r.sep) begin
        top_r <= 1'b1; // see (R11)
        if (mark == `TTYMF_MARK_STD &&
            control_word_r.word_idx <= `TTYMF_W_LINE1) begin
          working_register_r <= {11'h000, `TTYMF_C_SPACE}; // see (R5)
        end else begin
          working_register_r <= {11'h000, `TTYMF_C_LR}; // see (R5)
        end
      end else if (mark == `TTYMF_MARK_TOD) begin
        working_register_r <= ttymf_rotl4(tod_r, control_word_r.chr_idx);
        top_r <= 1'b0; // see (R17)
      end else begin
        working_register_r <= ttymf_rotl4(cur_word,
                                          control_word_r.chr_idx);
        top_r <= 1'b0; // see (R1) (R9)
      end
    end
  end
  // ----------------------------------------------------------------
  // Print-out register transfers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      por_data_r <= '0;
      por_high_load_r <= 1'b0;
      por_low_load_r <= 1'b0;
      por_start_r <= 1'b0;
    end else begin
      por_high_load_r <= state_r == TTYMF_ST_HIGH;
      por_low_load_r <= state_r == TTYMF_ST_LOW;
      por_start_r <= state_r == TTYMF_ST_LOW;
      if (state_r == TTYMF_ST_HIGH) begin
        por_data_r.busy <= 1'b1; // see (R20)
        por_data_r.top <= top_r; // see (R20)
      end
      if (state_r == TTYMF_ST_LOW) begin
        por_data_r.low <= working_register_r[3:0]; // see (R10)
      end
    end
  end
  // ----------------------------------------------------------------
  // Control word
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      control_word_r <= '{`TTYMF_W_FIRST, 2'h0, 1'b0};
      chk_r <= 5'h00;
    end else if (state_r == TTYMF_ST_WAIT && mark != `TTYMF_MARK_PIN &&
                 mark != `TTYMF_MARK_STD && mark != `TTYMF_MARK_INT &&
                 mark != `TTYMF_MARK_CHK && mark != `TTYMF_MARK_TOD) begin
      control_word_r <= '{`TTYMF_W_FIRST, 2'h0, 1'b0};
      chk_r <= 5'h00;
    end else if (pin_take && !pin_func && !pin_full) begin
      // see (R13)
      if (control_word_r.chr_idx == `TTYMF_LASTCHR ||
          (control_word_r.word_idx == `TTYMF_W_FIRST &&
           control_word_r.chr_idx == `TTYMF_W1_LASTCHR)) begin
        control_word_r.word_idx <= control_word_r.word_idx + 3'h1;
        control_word_r.chr_idx <= 2'h0;
      end else begin
        control_word_r.chr_idx <= control_word_r.chr_idx + 2'h1;
      end
    end else if (pin_take && pin_char == `TTYMF_C_PERIOD) begin
      control_word_r <= '{`TTYMF_W_INT0, 2'h0, 1'b0};
    end else if (state_r == TTYMF_ST_LOW) begin
      if (seq_end) begin
        // Time of day opens on its own line
        control_word_r <= '{`TTYMF_W_FIRST, 2'h0, 1'b1};
      end else if (mark == `TTYMF_MARK_CHK) begin
        chk_r <= chk_r + 5'h01;
      end else if (mark == `TTYMF_MARK_INT) begin
        if (control_word_r.chr_idx == `TTYMF_INT_LASTCHR ||
            int_next == 16'h0000) begin
          control_word_r.word_idx <= control_word_r.word_idx + 3'h1;
          control_word_r.chr_idx <= 2'h0;
        end else begin
          control_word_r.chr_idx <= control_word_r.chr_idx + 2'h1;
        end
      end else if (control_word_r.sep) begin
        control_word_r.sep <= 1'b0;
      end else if (control_word_r.chr_idx == `TTYMF_LASTCHR ||
                   (mark == `TTYMF_MARK_STD &&
                    control_word_r.word_idx == `TTYMF_W_FIRST &&
                    control_word_r.chr_idx == `TTYMF_W1_LASTCHR)) begin
        // see (R4) (R12)
        control_word_r.word_idx <= control_word_r.word_idx + 3'h1;
        control_word_r.chr_idx <= 2'h0;
        control_word_r.sep <= 1'b1;
      end else begin
        control_word_r.chr_idx <= control_word_r.chr_idx + 2'h1;
      end
    end
  end
  // Functional characters other than space, line return, bell return and period, or legal ones past word 7, make the message invalid
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_bad_r <= 1'b0;
    end else if (mark != `TTYMF_MARK_PIN) begin
      pin_bad_r <= 1'b0;
    end else if (pin_take && ((pin_func && pin_char != `TTYMF_C_SPACE &&
                 pin_char != `TTYMF_C_LR && pin_char != `TTYMF_C_LRBELL &&
                 pin_char != `TTYMF_C_PERIOD) || (!pin_func && pin_full))) begin
      pin_bad_r <= 1'b1; // see (R3)
    end
  end
  // ----------------------------------------------------------------
  // Message store; formatter writes win over software
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (pin_take && !pin_func && !pin_full) begin
      store_mem[grp_base | {4'h0, control_word_r.word_idx}] <= nib_word;
    end else if (pin_take && pin_char == `TTYMF_C_PERIOD) begin
      // see (R22)
      if (pin_bad_r || !pin_full) begin
        // see (R16)
        store_mem[grp_base] <= {12'h000, `TTYMF_MARK_INT};
        store_mem[grp_base | {4'h0, `TTYMF_W_INT0}] <= ttymf_pack3(
            `TTYMF_C_ONE, `TTYMF_C_L, `TTYMF_C_L);
        store_mem[grp_base | {4'h0, `TTYMF_W_INT1}] <= ttymf_pack3(
            `TTYMF_C_E, `TTYMF_C_G, `TTYMF_C_A);
        store_mem[grp_base | {4'h0, `TTYMF_W_INT2}] <= ttymf_pack3(
            `TTYMF_C_L, `TTYMF_C_DASH, `TTYMF_C_DASH);
      end else begin
        store_mem[grp_base] <= {12'h000, `TTYMF_MARK_DONE}; // see (R19)
      end
    end else if (state_r == TTYMF_ST_LOW) begin
      if (mark == `TTYMF_MARK_INT) begin
        // see (R15)
        store_mem[grp_base | {4'h0, control_word_r.word_idx}] <= int_next;
      end
      if (seq_end) begin
        store_mem[grp_base] <= {12'h000, (mark == `TTYMF_MARK_TOD) ?
            `TTYMF_MARK_NONE : `TTYMF_MARK_TOD}; // see (R17)
      end
    end else if (reg_wr && reg_addr[7] != `TTYMF_STORE_TOP) begin
      store_mem[reg_addr[6:0]] <= reg_wdata; // see (R6) (R7) (R8)
    end
  end
  // ----------------------------------------------------------------
  // Registers and hand-over to the request handler
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tod_r <= 16'h0000;
    end else if (reg_wr && reg_addr == `TTYMF_ADDR_TOD) begin
      tod_r <= reg_wdata;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      handoff_pend_r <= 1'b0;
      handoff_group_r <= 4'h0;
    end else if (pin_take && pin_char == `TTYMF_C_PERIOD && !pin_bad_r &&
                 pin_full) begin
      // A completion beats an acknowledge in the same cycle
      handoff_pend_r <= 1'b1; // see (R19)
      handoff_group_r <= grp_r;
    end else if (reg_wr && reg_addr == `TTYMF_ADDR_ACK) begin
      handoff_pend_r <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_addr[7] != `TTYMF_STORE_TOP) begin
      reg_rdata_r <= store_mem[reg_addr[6:0]];
    end else if (reg_addr == `TTYMF_ADDR_TOD) begin
      reg_rdata_r <= tod_r;
    end else if (reg_addr == `TTYMF_ADDR_STATUS) begin
      reg_rdata_r <= {handoff_pend_r, 3'h0, handoff_group_r, grp_r,
                      state_r};
    end else begin
      reg_rdata_r <= 16'h0000;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking ttymf_cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  high_sets_busy_a: assert property ( // see (R20)
    por_high_load_r |-> por_data_r.busy && por_data_r.top == $past(top_r))
    else $error("high part transfer without busy or top bit");
  low_after_high_a: assert property ( // see (R10)
    por_high_load_r |=> por_low_load_r && por_start_r ##1 !por_low_load_r)
    else $error("low part transfer not right after high part");
  idle_before_send_a: assert property ( // see (R21)
    state_r == TTYMF_ST_LOAD |-> $past(scan_tick && !por_busy))
    else $error("character started while printer busy");
  space_between_a: assert property ( // see (R5)
    state_r == TTYMF_ST_LOAD && mark == `TTYMF_MARK_STD &&
    control_word_r.sep && control_word_r.word_idx <= `TTYMF_W_LINE1
    |=> working_register_r[4:0] == `TTYMF_C_SPACE && top_r)
    else $error("missing space between words");
  line_return_a: assert property ( // see (R5)
    state_r == TTYMF_ST_LOAD && mark == `TTYMF_MARK_STD &&
    control_word_r.sep && control_word_r.word_idx > `TTYMF_W_LINE1
    |=> ##2 por_low_load_r &&
    {por_data_r.top, por_data_r.low} == `TTYMF_C_LR)
    else $error("missing line return before word");
  legal_top_zero_a: assert property ( // see (R1)
    state_r == TTYMF_ST_LOAD && mark == `TTYMF_MARK_STD &&
    !control_word_r.sep |=> ##1 por_high_load_r && !por_data_r.top)
    else $error("legal character sent with top bit set");
  func_dropped_a: assert property ( // see (R13)
    pin_take && pin_func |=> $stable(control_word_r.word_idx) ||
    control_word_r.word_idx == `TTYMF_W_INT0)
    else $error("functional character stored in print-in");
  period_ends_a: assert property ( // see (R22)
    pin_take && pin_char == `TTYMF_C_PERIOD |=> mark != `TTYMF_MARK_PIN)
    else $error("period did not end print-in");
  int_shift_a: assert property ( // see (R15)
    state_r == TTYMF_ST_LOW && mark == `TTYMF_MARK_INT |=>
    $past(int_next) == store_mem[grp_base | {4'h0, $past(
      control_word_r.word_idx)}])
    else $error("intermediate word not shifted back");
  handoff_mark_a: assert property ( // see (R19)
    $rose(handoff_pend_r) |-> store_mem[grp_base] == {12'h000,
      `TTYMF_MARK_DONE})
    else $error("hand-over without done mark");
  std_done_c: cover property (seq_end && mark == `TTYMF_MARK_STD &&
                              state_r == TTYMF_ST_LOW);
  illegal_c: cover property (pin_take && pin_char == `TTYMF_C_PERIOD &&
                             pin_bad_r);
  check_done_c: cover property (seq_end && mark == `TTYMF_MARK_CHK &&
                                state_r == TTYMF_ST_LOW);
  tod_done_c: cover property (seq_end && mark == `TTYMF_MARK_TOD &&
                              state_r == TTYMF_ST_LOW);
endmodule : ttymf_formatter

// file: test/ttymf_printer_model.sv
// Behavioural print-out register and distributor seen from the formatter.
// Assumes one sys_clk domain; busy stays up a fixed time after each start.
`timescale 1ns/100ps
module ttymf_printer_model import ttymf_pkg::*; #(
  parameter int BUSY_CYCLES = 6
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire ttymf_por_type por_data,
  input wire logic high_load,
  input wire logic low_load,
  input wire logic start,
  output logic por_busy
);
  logic [4:0] got[$];
  int errs = 0;
  int cnt;
  // ----------------------------------------------------------------
  // Busy-idle bit: cleared only when the character has gone out
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      por_busy <= 1'b0;
      cnt <= 0;
    end else begin
      if (high_load) por_busy <= 1'b1;
      if (start) cnt <= BUSY_CYCLES;
      else if (cnt > 0) begin
        cnt <= cnt - 1;
        if (cnt == 1) por_busy <= 1'b0;
      end
    end
  end
  // A write while still busy would garble the character on the loop
  always @(posedge sys_clk) begin
    if (high_load && por_busy) errs++;
    if (low_load) begin
      if (por_data.busy !== 1'b1 || start !== 1'b1) errs++;
      got.push_back({por_data.top, por_data.low});
    end
  end
endmodule : ttymf_printer_model

// file: test/tty_message_formatter_tb_top.sv
// Self-checking bench: register port, print-out, print-in and check mode.
// Assumes the printer model answers busy-idle; scans come every 16 cycles.
`timescale 1ns/100ps
`include "ttymf_map.svh"
`define CHK(what, e, g) begin checks++; if ((g) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %s exp %h got %h", what, e, g); end end
module tty_message_formatter_tb_top import ttymf_pkg::*;;
  logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic scan_tick = 1'b0, pin_strobe = 1'b0, por_busy;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata_r, rv;
  logic [4:0] pin_char = 5'h00;
  logic [3:0] scan_cnt = 4'h0, handoff_group_r;
  ttymf_por_type por_data_r;
  logic por_high_load_r, por_low_load_r, por_start_r, handoff_pend_r;
  logic [4:0] exp_q[$];
  logic [15:0] words[1:7] = '{16'h1230, 16'h4567, 16'h89ab, 16'hcdef,
                              16'h0f1e, 16'h2d3c, 16'h4b5a};
  logic [15:0] tod = 16'h2059;
  int mismatches = 0, checks = 0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    scan_cnt <= scan_cnt + 4'h1;
    scan_tick <= (scan_cnt == 4'h0);
  end
  ttymf_formatter u_ttymf_formatter (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .scan_tick(scan_tick),
    .por_busy(por_busy), .pin_strobe(pin_strobe), .pin_char(pin_char),
    .por_data_r(por_data_r), .por_high_load_r(por_high_load_r),
    .por_low_load_r(por_low_load_r), .por_start_r(por_start_r),
    .handoff_pend_r(handoff_pend_r), .handoff_group_r(handoff_group_r));
  ttymf_printer_model u_ttymf_printer_model (.sys_clk(sys_clk),
    .rst_b(rst_b), .por_data(por_data_r), .high_load(por_high_load_r),
    .low_load(por_low_load_r), .start(por_start_r), .por_busy(por_busy));
  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata_r;
  endtask : rd
  task automatic pin(input logic [4:0] c);
    @(posedge sys_clk);
    pin_strobe <= 1'b1;
    pin_char <= c;
    @(posedge sys_clk);
    pin_strobe <= 1'b0;
  endtask : pin
  task automatic push_tod();
    exp_q.push_back(`TTYMF_C_LR);
    for (int k = 0; k < 4; k++) exp_q.push_back({1'b0, tod[15-4*k -: 4]});
  endtask : push_tod
  // Waits for the printer to catch up, then compares character by character
  task automatic flush();
    for (int t = 0; t < 6000; t++) begin
      if (u_ttymf_printer_model.got.size() >= exp_q.size()) break;
      @(posedge sys_clk);
    end
    `CHK("char count", exp_q.size(), u_ttymf_printer_model.got.size())
    for (int i = 0; i < exp_q.size(); i++)
      `CHK("printed char", exp_q[i], u_ttymf_printer_model.got[i])
    exp_q.delete();
    u_ttymf_printer_model.got.delete();
  endtask : flush
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    wr(`TTYMF_ADDR_TOD, tod);
    rd(`TTYMF_ADDR_TOD);
    `CHK("time of day", tod, rv)
    for (int g = 0; g < 16; g++) wr(8'(g * 8), 16'h0000);
    for (int w = 1; w <= 7; w++) wr(8'(w), words[w]);
    for (int w = 1; w <= 7; w++) begin
      if (w == 2 || w == 3) exp_q.push_back(`TTYMF_C_SPACE);
      if (w >= 4) exp_q.push_back(`TTYMF_C_LR);
      for (int k = 0; k < ((w == 1) ? 3 : 4); k++)
        exp_q.push_back({1'b0, words[w][15-4*k -: 4]});
    end
    push_tod();
    wr(8'h00, 16'h0001);
    flush();
    rd(8'h00);
    `CHK("mark cleared", 16'h0000, rv)
    for (int c = 0; c < 32; c++) exp_q.push_back(5'(c));
    push_tod();
    wr(8'h18, 16'h0003);
    flush();
    wr(8'h08, 16'h0002);
    repeat (40) @(posedge sys_clk);
    for (int i = 0; i < 27; i++) begin
      pin(5'(i % 16));
      if (i == 5) pin(`TTYMF_C_SPACE);
    end
    pin(`TTYMF_C_PERIOD);
    #1 `CHK("handoff", 5'h11, {handoff_pend_r, handoff_group_r})
    rd(8'h09);
    `CHK("word one", 12'h012, rv[15:4])
    rd(8'h0a);
    `CHK("word two", 16'h3456, rv)
    rd(8'h0f);
    `CHK("word seven", 16'h789a, rv)
    rd(`TTYMF_ADDR_STATUS);
    `CHK("status", 8'h81, rv[15:8])
    wr(`TTYMF_ADDR_ACK, 16'h0000);
    rd(`TTYMF_ADDR_STATUS);
    `CHK("acked", 1'b0, rv[15])
    wr(8'h10, 16'h0002);
    repeat (40) @(posedge sys_clk);
    pin(5'h07);
    pin(`TTYMF_C_PERIOD);
    exp_q = '{`TTYMF_C_ONE, `TTYMF_C_L, `TTYMF_C_L, `TTYMF_C_E,
              `TTYMF_C_G, `TTYMF_C_A, `TTYMF_C_L};
    push_tod();
    flush();
    `CHK("printer protocol", 0, u_ttymf_printer_model.errs)
    finish_test();
  end
endmodule : tty_message_formatter_tb_top
